// ### bench/mecl_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// requesting source: ordinary even parity check on read data
module mecl_src_model (
   input wire logic [15:0] rd_data,
   input wire logic rd_parity,
   output logic fault
);
   // the channel has no other error line, so a bad parity is the only way
   // an uncorrectable memory fault can reach the source
   assign fault = ^{rd_data, rd_parity};
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // =====================================================
   // stimulus and observed signals
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] wr_req = 2'h0, rd_valid = 2'h0;
   logic [1:0] wr_req_n = 2'h0, rd_valid_n = 2'h0;
   logic svc_sel_n = 1'b0;
   logic [31:0] wr_data = 32'h0;
   logic [41:0] rd_word = 42'h0;
   logic [35:0] rd_addr = 36'h0;
   logic [18:0] narrow_addr = 19'h0;
   logic [2:0] crate_sw = 3'h5, svc_crate_sel = 3'h0;
   logic svc_sel = 1'b0, svc_rd = 1'b0, svc_clr = 1'b0, svc_bank = 1'b0;
   logic [8:0] svc_index = 9'h0;
   logic [1:0] store_valid, rd_done, rd_parity, fault, wide_parity;
   logic [41:0] store_word;
   logic [31:0] rd_data, wide_data;
   logic wide_valid, narrow_bank_y, svc_ack, svc_bit;
   logic [17:0] narrow_local;
   logic [2:0] svc_crate;
   logic [15:0] d, dx, dy;
   logic [18:0] a;
   int c;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [39:0] exp_q[$];
   always #5 clk_sys = ~clk_sys;
   // =====================================================
   // design and source models
   mecl_bank_pair #(.NPORT(1), .WIDE_PORT(0)) i_mecl_bank_pair (
      .CLK_SYS(clk_sys), .RST(rst), .WR_REQ(wr_req), .WR_DATA(wr_data),
      .STORE_VALID(store_valid), .STORE_WORD(store_word),
      .RD_VALID(rd_valid), .RD_WORD(rd_word), .RD_ADDR(rd_addr),
      .RD_DONE(rd_done), .RD_DATA(rd_data), .RD_PARITY(rd_parity),
      .WIDE_VALID(wide_valid), .WIDE_DATA(wide_data),
      .WIDE_PARITY(wide_parity), .NARROW_ADDR(narrow_addr),
      .NARROW_BANK_Y(narrow_bank_y), .NARROW_LOCAL(narrow_local),
      .CRATE_SW(crate_sw), .SVC_SEL(svc_sel),
      .SVC_CRATE_SEL(svc_crate_sel), .SVC_RD(svc_rd), .SVC_CLR(svc_clr),
      .SVC_BANK(svc_bank), .SVC_INDEX(svc_index), .SVC_ACK(svc_ack),
      .SVC_BIT(svc_bit), .SVC_CRATE(svc_crate));
   mecl_src_model i_mecl_src_model[1:0] (.rd_data(rd_data),
      .rd_parity(rd_parity), .fault(fault));
   // =====================================================
   // helpers
   function automatic logic [20:0] enc(input logic [15:0] v);
      logic [20:0] w;
      int j;
      w = 21'h0;
      j = 0;
      for (int p = 1; p <= 21; p++) if ((p & (p - 1)) != 0) begin
         w[p-1] = v[j];
         j++;
      end
      // check bit slots start at 0, so xor over all members is safe
      for (int k = 0; k < 5; k++) for (int p = 1; p <= 21; p++)
         if (((p >> k) & 1) != 0) w[(1<<k)-1] = w[(1<<k)-1] ^ w[p-1];
      return w;
   endfunction
   task automatic chk(input string nm, input logic [39:0] seen,
         input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pop_chk(input string nm, input logic [39:0] seen);
      chk(nm, seen, (exp_q.size() > 0) ? exp_q.pop_front() : 40'h0);
   endtask
   // strobes take their pending value once per falling edge, so a
   // back to back request never drops and rises in one time step
   task automatic tick;
      wr_req = wr_req_n;
      rd_valid = rd_valid_n;
      svc_sel = svc_sel_n;
      wr_req_n = 2'h0;
      rd_valid_n = 2'h0;
      svc_sel_n = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic wr(input int ch, input logic [15:0] v);
      wr_req_n[ch] = 1'b1;
      wr_data[ch*16+:16] = v;
      exp_q.push_back({4'h4, 4'h0, 11'h0, enc(v)});
   endtask
   task automatic rdx(input int ch, input logic [15:0] v,
         input logic [20:0] flip, input logic [2:0] m, input logic multi);
      rd_valid_n[ch] = 1'b1;
      rd_word[ch*21+:21] = enc(v) ^ flip;
      rd_addr[ch*18+:18] = {m, 15'h0};
      exp_q.push_back({4'h1, 3'h0, multi, 16'h0, v});
   endtask
   task automatic svc(input logic bank, input logic [8:0] idx,
         input logic rdn, input logic [2:0] crate, input logic bit_exp);
      svc_sel_n = 1'b1;
      svc_crate_sel = crate;
      svc_rd = rdn;
      svc_clr = !rdn;
      svc_bank = bank;
      svc_index = idx;
      if (crate == 3'h5) exp_q.push_back({4'h3, 3'h0, bit_exp, 29'h0, crate});
   endtask
   task automatic close_out;
      // a note still queued is a result that never came out
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("MISMATCH pending exp 0 seen %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // =====================================================
   // monitor: oldest note against each result
   always @(negedge clk_sys) if (!rst) begin
      for (int k = 0; k < 2; k++) if (store_valid[k] === 1'b1)
         pop_chk("store", {8'h40, 11'h0, store_word[k*21+:21]});
      for (int k = 0; k < 2; k++) if (rd_done[k] === 1'b1)
         pop_chk("read", {7'h08, fault[k], 16'h0, rd_data[k*16+:16]});
      if (wide_valid === 1'b1)
         pop_chk("wide", {6'h08, wide_parity, wide_data});
      if (svc_ack === 1'b1)
         pop_chk("svc", {7'h18, svc_bit, 29'h0, svc_crate});
   end
   initial begin
      #20000;
      n_mismatch++;
      close_out;
   end
   // =====================================================
   // tests
   initial begin
      void'($urandom(10));
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) tick;
      for (int i = 0; i < 3; i++) begin
         wr(0, 16'($urandom));
         wr(1, 16'($urandom));
         tick;
      end
      repeat (2) tick;
      $display("test writes done");
      // every single position, banks alternating by position, read clears, other log untouched
      for (int p = 1; p <= 21; p++) begin
         d = 16'($urandom);
         c = p % 2;
         rdx(c, d, 21'h1 << (p - 1), 3'(p), 1'b0);
         repeat (2) tick;
         svc(1'(c), {1'b0, 3'(p), 5'(p)}, 1'b1, 3'h5, 1'b1);
         tick;
         svc(1'(c), {1'b0, 3'(p), 5'(p)}, 1'b1, 3'h5, 1'b0);
         tick;
         svc(1'(1 - c), {1'b0, 3'(p), 5'(p)}, 1'b1, 3'h5, 1'b0);
         tick;
      end
      $display("test singles done");
      // wide read with one single and one forced fault, then service ops
      dx = 16'($urandom);
      dy = 16'($urandom);
      rdx(0, dx, 21'h10, 3'h2, 1'b0);
      rdx(1, dy, 21'h8080, 3'h6, 1'b1);
      exp_q.push_back({4'h2, 2'h0, ^dx, ~^dy, dx, dy});
      repeat (2) tick;
      svc(1'b1, {1'b1, 3'h6, 5'h0}, 1'b1, 3'h2, 1'b0);
      tick;
      svc(1'b1, {1'b1, 3'h6, 5'h0}, 1'b1, 3'h5, 1'b1);
      tick;
      svc(1'b0, {1'b0, 3'h2, 5'h5}, 1'b1, 3'h5, 1'b1);
      tick;
      rdx(1, dy, 21'h8080, 3'h6, 1'b1);
      repeat (2) tick;
      svc(1'b1, {1'b1, 3'h6, 5'h0}, 1'b0, 3'h5, 1'b0);
      tick;
      svc(1'b1, {1'b1, 3'h6, 5'h0}, 1'b1, 3'h5, 1'b0);
      tick;
      $display("test multi and service done");
      for (int i = 0; i < 8; i++) begin
         a = 19'($urandom);
         narrow_addr = a;
         tick;
         chk("narrow", {21'h0, narrow_bank_y, narrow_local},
            {21'h0, a[0], a[18:1]});
      end
      $display("test narrow done");
      repeat (3) tick;
      close_out;
   end
endmodule
`default_nettype wire

// ### hdl/mecl_bank_pair.sv
`timescale 1ns/1ps
`default_nettype none
module mecl_bank_pair #(
   parameter int NPORT = 4,
   parameter int WIDE_PORT = 0
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [2*NPORT-1:0] WR_REQ,
   input wire logic [2*NPORT*mecl_pkg::DATA_W-1:0] WR_DATA,
   output logic [2*NPORT-1:0] STORE_VALID,
   output logic [2*NPORT*mecl_pkg::WORD_W-1:0] STORE_WORD,
   input wire logic [2*NPORT-1:0] RD_VALID,
   input wire logic [2*NPORT*mecl_pkg::WORD_W-1:0] RD_WORD,
   input wire logic [2*NPORT*mecl_pkg::ADDR_W-1:0] RD_ADDR,
   output logic [2*NPORT-1:0] RD_DONE,
   output logic [2*NPORT*mecl_pkg::DATA_W-1:0] RD_DATA,
   output logic [2*NPORT-1:0] RD_PARITY,
   output logic WIDE_VALID,
   output logic [2*mecl_pkg::DATA_W-1:0] WIDE_DATA,
   output logic [1:0] WIDE_PARITY,
   input wire logic [mecl_pkg::ADDR_W:0] NARROW_ADDR,
   output logic NARROW_BANK_Y,
   output logic [mecl_pkg::ADDR_W-1:0] NARROW_LOCAL,
   input wire logic [mecl_pkg::CRATE_W-1:0] CRATE_SW,
   input wire logic SVC_SEL,
   input wire logic [mecl_pkg::CRATE_W-1:0] SVC_CRATE_SEL,
   input wire logic SVC_RD,
   input wire logic SVC_CLR,
   input wire logic SVC_BANK,
   input wire logic [mecl_pkg::LOG_AW-1:0] SVC_INDEX,
   output logic SVC_ACK,
   output logic SVC_BIT,
   output logic [mecl_pkg::CRATE_W-1:0] SVC_CRATE
);
   localparam int NC = mecl_pkg::NBANK * NPORT;
   localparam int DW = mecl_pkg::DATA_W;
   localparam int WW = mecl_pkg::WORD_W;
   localparam int AW = mecl_pkg::ADDR_W;
   localparam int WX = mecl_pkg::BANK_X * NPORT + WIDE_PORT;
   localparam int WY = mecl_pkg::BANK_Y * NPORT + WIDE_PORT;

   if (NPORT < 1 || NPORT > 4 ||
         WIDE_PORT < 0 || WIDE_PORT >= NPORT) begin : g_bad
      $error("port count or wide port out of range");
   end

   logic [NC-1:0] ev;
   logic [NC-1:0] sgl;
   logic [NC-1:0] mlt;
   logic [mecl_pkg::LOG_AW-1:0] ev_idx [NC];

   // =====================================================
   // per-port correction and registered outputs
   // one network per port so no port waits on another's check
   for (genvar c = 0; c < NC; c++) begin : g_port
      logic [DW-1:0] enc_in;
      logic [WW-1:0] enc_out;
      logic [DW-1:0] dec_data;
      logic [mecl_pkg::POS_W-1:0] dec_pos;
      logic sv, next_sv, rdn, next_rdn, par, next_par;
      logic [WW-1:0] sw, next_sw;
      logic [DW-1:0] rd, next_rd;

      assign enc_in = WR_DATA[c*DW +: DW];

      mecl_port_ecc u_ecc (
         .wr_data(enc_in),
         .store_word(enc_out),
         .rd_word(RD_WORD[c*WW +: WW]),
         .rd_data(dec_data),
         .single(sgl[c]),
         .multi(mlt[c]),
         .pos(dec_pos)
      );

      assign ev[c] = RD_VALID[c] && (sgl[c] || mlt[c]);
      assign ev_idx[c] = {mlt[c],
         RD_ADDR[c*AW + mecl_pkg::MOD_LSB +: mecl_pkg::MOD_W], dec_pos};

      always_comb begin
         next_sv = WR_REQ[c];
         next_sw = WR_REQ[c] ? enc_out : sw;
         next_rdn = RD_VALID[c];
         next_rd = RD_VALID[c] ? dec_data : rd;
         // even parity; a multi-bit fault flips it for the source
         // to catch with its own parity check
         next_par = RD_VALID[c] ? ((^dec_data) ^ mlt[c]) : par;
      end

      always_ff @(posedge CLK_SYS or posedge RST) begin
         if (RST) begin
            sv <= 1'b0;
            sw <= '0;
            rdn <= 1'b0;
            rd <= '0;
            par <= 1'b0;
         end else begin
            sv <= next_sv;
            sw <= next_sw;
            rdn <= next_rdn;
            rd <= next_rd;
            par <= next_par;
         end
      end

      assign STORE_VALID[c] = sv;
      assign STORE_WORD[c*WW +: WW] = sw;
      assign RD_DONE[c] = rdn;
      assign RD_DATA[c*DW +: DW] = rd;
      assign RD_PARITY[c] = par;
   end

   // =====================================================
   // error logs, one per bank
   logic [mecl_pkg::CRATE_W-1:0] crate_s1, crate_s2, crate_q;
   logic svc_hit;
   logic [mecl_pkg::LOG_DEPTH-1:0] log_mem [mecl_pkg::NBANK];
   logic [mecl_pkg::LOG_DEPTH-1:0] next_log [mecl_pkg::NBANK];

   assign svc_hit = SVC_SEL && (SVC_CRATE_SEL == crate_s2);

   always_comb begin
      logic set;
      logic clr;
      set = 1'b0;
      clr = 1'b0;
      for (int b = 0; b < mecl_pkg::NBANK; b++) begin
         for (int e = 0; e < mecl_pkg::LOG_DEPTH; e++) begin
            set = 1'b0;
            for (int p = 0; p < NPORT; p++) begin
               if (ev[b*NPORT+p] && (32'(ev_idx[b*NPORT+p]) == e)) begin
                  set = 1'b1;
               end
            end
            clr = svc_hit && (SVC_RD || SVC_CLR) &&
               (32'(SVC_BANK) == b) && (32'(SVC_INDEX) == e);
            // a new error in the clearing cycle survives the clear
            next_log[b][e] = set || (log_mem[b][e] && !clr);
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         log_mem[0] <= '0;
         log_mem[1] <= '0;
      end else begin
         log_mem[0] <= next_log[0];
         log_mem[1] <= next_log[1];
      end
   end

   // =====================================================
   // service channel and crate switch
   logic ack, next_ack, sbit, next_sbit, svc_peek;
   logic wv, next_wv, nb, next_nb;
   logic [AW-1:0] nl, next_nl;

   assign svc_peek = log_mem[SVC_BANK][SVC_INDEX];

   always_comb begin
      next_ack = svc_hit && (SVC_RD || SVC_CLR);
      next_sbit = (svc_hit && SVC_RD) ? svc_peek : 1'b0;
      next_wv = RD_VALID[WX] && RD_VALID[WY];
      next_nb = NARROW_ADDR[0];
      next_nl = NARROW_ADDR[AW:1];
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         crate_s1 <= '0;
         crate_s2 <= '0;
         crate_q <= '0;
         ack <= 1'b0;
         sbit <= 1'b0;
         wv <= 1'b0;
         nb <= 1'b0;
         nl <= '0;
      end else begin
         crate_s1 <= CRATE_SW;
         crate_s2 <= crate_s1;
         crate_q <= crate_s2;
         ack <= next_ack;
         sbit <= next_sbit;
         wv <= next_wv;
         nb <= next_nb;
         nl <= next_nl;
      end
   end

   assign SVC_ACK = ack;
   assign SVC_BIT = sbit;
   assign SVC_CRATE = crate_q;
   assign WIDE_VALID = wv;
   // bank X word is the high half: it holds the even 16-bit word
   assign WIDE_DATA = {RD_DATA[WX*DW +: DW], RD_DATA[WY*DW +: DW]};
   assign WIDE_PARITY = {RD_PARITY[WX], RD_PARITY[WY]};
   assign NARROW_BANK_Y = nb;
   assign NARROW_LOCAL = nl;

   // =====================================================
   // checks on port 0 of bank X, the service channel, the crate switch and the wide and narrow paths
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_svc_read;
      svc_hit && SVC_RD;
   endsequence

   property p_store;
      WR_REQ[0] |=> STORE_VALID[0] && STORE_WORD[2] == $past(WR_DATA[0])
         && STORE_WORD[20] == $past(WR_DATA[15]);
   endproperty
   a_store: assert property (p_store) else $error("store word wrong");

   property p_done;
      RD_VALID[0] |=> RD_DONE[0] ##1 (RD_DONE[0] == $past(RD_VALID[0]));
   endproperty
   a_done: assert property (p_done) else $error("read not answered");

   property p_silent;
      RD_VALID[0] && sgl[0] |=> RD_PARITY[0] == ^RD_DATA[DW-1:0];
   endproperty
   a_silent: assert property (p_silent) else $error("single flagged");

   property p_force;
      RD_VALID[0] && mlt[0] |=> RD_PARITY[0] != ^RD_DATA[DW-1:0];
   endproperty
   a_force: assert property (p_force) else $error("parity not forced");

   property p_log;
      ev[0] |=> log_mem[0][$past(ev_idx[0])];
   endproperty
   a_log: assert property (p_log) else $error("error not logged");

   property p_hold;
      log_mem[0][0] && !(svc_hit && (SVC_RD || SVC_CLR) && !SVC_BANK
         && SVC_INDEX == 9'h000) |=> log_mem[0][0];
   endproperty
   a_hold: assert property (p_hold) else $error("log entry lost");

   property p_svc;
      s_svc_read |=> SVC_ACK && SVC_BIT == $past(svc_peek);
   endproperty
   a_svc: assert property (p_svc) else $error("service read wrong");

   property p_crate;
      $stable(CRATE_SW) [*4] |-> SVC_CRATE == CRATE_SW;
   endproperty
   a_crate: assert property (p_crate) else $error("crate not shown");

   property p_wide;
      RD_VALID[WX] && RD_VALID[WY] |=> WIDE_VALID &&
         WIDE_DATA[DW-1:0] == RD_DATA[WY*DW +: DW];
   endproperty
   a_wide: assert property (p_wide) else $error("wide word wrong");

   property p_narrow;
      1'b1 |=> NARROW_BANK_Y == $past(NARROW_ADDR[0]) &&
         NARROW_LOCAL == $past(NARROW_ADDR[AW:1]);
   endproperty
   a_narrow: assert property (p_narrow) else $error("interleave wrong");
endmodule
`default_nettype wire

// ### hdl/mecl_pkg.sv
// Behaviour
// - each write gets five check bits stored beside sixteen data bits
// - every port owns a private correction network
// - reads correct single-bit errors and flag multiple-bit errors whose syndrome is above 21
// - read errors flagged as multiple-bit (syndrome above 21) force a parity error to the source
// - corrected single-bit errors are never signalled to the source
// - every single or multiple error of a bank is logged for that bank
// - each log holds 512 one-bit entries, address names the failing chip
// - two separate logs, one for bank X and one for bank Y
// - crate number 0 to 7 from a switch identifies the log module
// - host reads the logs on the service channel as one device
// - a 32-bit source reads bank X and bank Y words together
// - a 16-bit source sees the banks interleaved on word addresses
// - five-bit check code attached on write and verified on read
// - storage words are 21 bits: data plus check bits
`default_nettype none
package mecl_pkg;
   // =====================================================
   // word layout
   localparam int DATA_W = 16;
   localparam int CHECK_W = 5;
   localparam int WORD_W = DATA_W + CHECK_W;
   localparam int POS_W = 5;
   // =====================================================
   // banks and addressing
   localparam int NBANK = 2;
   localparam int BANK_X = 0;
   localparam int BANK_Y = 1;
   localparam int ADDR_W = 18;
   localparam int MOD_LSB = 15;
   localparam int MOD_W = 3;
   // =====================================================
   // error log: index = {multi, module, bit position}
   localparam int LOG_DEPTH = 512;
   localparam int LOG_AW = 9;
   localparam int CRATE_W = 3;
endpackage
`default_nettype wire

// ### hdl/mecl_port_ecc.sv
`timescale 1ns/1ps
`default_nettype none
module mecl_port_ecc (
   input wire logic [mecl_pkg::DATA_W-1:0] wr_data,
   output logic [mecl_pkg::WORD_W-1:0] store_word,
   input wire logic [mecl_pkg::WORD_W-1:0] rd_word,
   output logic [mecl_pkg::DATA_W-1:0] rd_data,
   output logic single,
   output logic multi,
   output logic [mecl_pkg::POS_W-1:0] pos
);
   // =====================================================
   // encoder: hamming positions 1..21, checks at powers of two
   always_comb begin
      int d;
      logic [mecl_pkg::CHECK_W-1:0] chk;
      d = 0;
      chk = '0;
      store_word = '0;
      for (int i = 1; i <= mecl_pkg::WORD_W; i++) begin
         if ((i & (i - 1)) != 0) begin
            store_word[i-1] = wr_data[d];
            d++;
         end
      end
      for (int i = 1; i <= mecl_pkg::WORD_W; i++) begin
         for (int k = 0; k < mecl_pkg::CHECK_W; k++) begin
            if (i[k] && ((i & (i - 1)) != 0)) begin
               chk[k] = chk[k] ^ store_word[i-1];
            end
         end
      end
      for (int k = 0; k < mecl_pkg::CHECK_W; k++) begin
         store_word[(1 << k) - 1] = chk[k];
      end
   end
   // =====================================================
   // decoder: with only five check bits some double errors alias
   // to a single position; syndromes above 21 are always flagged
   always_comb begin
      int d;
      logic [mecl_pkg::POS_W-1:0] syn;
      logic [mecl_pkg::WORD_W-1:0] fixed;
      d = 0;
      syn = '0;
      fixed = rd_word;
      rd_data = '0;
      for (int i = 1; i <= mecl_pkg::WORD_W; i++) begin
         if (rd_word[i-1]) begin
            syn = syn ^ 5'(i);
         end
      end
      single = (syn != 5'h00) && (32'(syn) <= mecl_pkg::WORD_W);
      multi = 32'(syn) > mecl_pkg::WORD_W;
      if (single) begin
         fixed[syn - 5'h01] = ~rd_word[syn - 5'h01];
      end
      for (int i = 1; i <= mecl_pkg::WORD_W; i++) begin
         if ((i & (i - 1)) != 0) begin
            rd_data[d] = fixed[i-1];
            d++;
         end
      end
      pos = multi ? 5'h00 : syn;
   end
endmodule
`default_nettype wire
